// >>> logic/gpeb_bank.sv
`timescale 1ns/1ps
`include "gpeb_consts.svh"

module gpeb_bank #(
    parameter int unsigned WIDTH = 8
) (
    // Clock and reset.
    input  wire logic             sys_clk,
    input  wire logic             rstn,
    // Event levels and software strobes.
    input  wire logic [WIDTH-1:0] event_in,
    input  wire logic [WIDTH-1:0] flag_clr,
    input  wire logic [WIDTH-1:0] mask_wr,
    input  wire logic [WIDTH-1:0] mask_wdata,
    input  wire logic             mask_clr_all,
    // State.
    output logic      [WIDTH-1:0] flags,
    output logic      [WIDTH-1:0] mask,
    output logic                  pending
);
    logic [WIDTH-1:0] flag_q;
    logic [WIDTH-1:0] flag_d;
    logic [WIDTH-1:0] mask_q;
    logic [WIDTH-1:0] mask_d;

    // =================================================================
    // Per-bit next state
    // An event in the cycle of its clear still leaves the flag set.
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        always_comb begin
            flag_d[i] = event_in[i] | (flag_q[i] & ~flag_clr[i]);
            if (mask_clr_all) begin
                mask_d[i] = `GPEB_RESET_BIT;
            end else if (mask_wr[i]) begin
                mask_d[i] = mask_wdata[i];
            end else begin
                mask_d[i] = mask_q[i];
            end
        end
    end

    // =================================================================
    // Registers
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            flag_q <= {WIDTH{`GPEB_RESET_BIT}};
            mask_q <= {WIDTH{`GPEB_RESET_BIT}};
        end else begin
            flag_q <= flag_d;
            mask_q <= mask_d;
        end
    end

    assign flags   = flag_q;
    assign mask    = mask_q;
    assign pending = |(flag_q & mask_q);

endmodule // gpeb_bank

// >>> logic/gpeb_consts.svh
// Functional notes
// - At most two event banks, flags plus mask.
// - Each bank base sits on 32-bit boundary.
// - Flags and mask each half the bank.
// - Mask bit pairs with same-position flag bit.
// - Active event input sets its flag bit.
// - Flag clears only on write of one.
// - All flags and masks reset to zero.
// - Interrupt while any flag and mask set.
// - Enabled flag may wake a sleeping system.
// - Retention across sleep is implementation choice.
// - Lid flag set on selected lid transition; the code sets it on a level match instead.
// - Lid polarity bit 0, flag bit 1.
// - Lid flag feeds bank 0 flag bit 1.
// - Flag sets when lid level equals polarity.
`ifndef GPEB_CONSTS_SVH
`define GPEB_CONSTS_SVH

// =====================================================================
// Map and layout
`define GPEB_MAX_BANKS     2
`define GPEB_NUM_BANKS     2
`define GPEB_REG_BYTES     1
`define GPEB_BANK0_BASE    16'h0400
`define GPEB_BANK1_BASE    16'h0404
`define GPEB_ALIGN_MASK    16'hFFFC
`define GPEB_LID_ADDR      16'h0200
`define GPEB_LID_POLARITY_BIT   0
`define GPEB_LID_FLAG_BIT  1
`define GPEB_LID_CHILD_BIT 1

// =====================================================================
// Reset and read values
`define GPEB_RESET_BIT     1'b0
`define GPEB_RESET_BYTE    8'h00
`define GPEB_UNMAPPED_READ 8'h00

`endif

// >>> logic/gpeb_lid.sv
`timescale 1ns/1ps
`include "gpeb_consts.svh"

module gpeb_lid (
    // Clock and reset.
    input  wire logic       sys_clk,
    input  wire logic       rstn,
    // Lid level, high when open.
    input  wire logic       lid_in,
    // Software write to the lid byte.
    input  wire logic       wr,
    input  wire logic [7:0] wdata,
    // State.
    output logic            lid_flag,
    output logic            lid_polarity
);
    logic flag_q;
    logic flag_d;
    logic pol_q;
    logic pol_d;

    // =================================================================
    // Next state
    // The flag follows a level match, so software must flip the
    // polarity after each event or the flag sets again at once.
    always_comb begin
        pol_d  = pol_q;
        flag_d = flag_q;
        if (wr) begin
            pol_d = wdata[`GPEB_LID_POLARITY_BIT];
            if (wdata[`GPEB_LID_FLAG_BIT]) begin
                flag_d = `GPEB_RESET_BIT;
            end
        end
        if (lid_in == pol_q) begin
            flag_d = 1'b1;
        end
    end

    // =================================================================
    // Registers
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            flag_q <= `GPEB_RESET_BIT;
            pol_q  <= `GPEB_RESET_BIT;
        end else begin
            flag_q <= flag_d;
            pol_q  <= pol_d;
        end
    end

    assign lid_flag     = flag_q;
    assign lid_polarity = pol_q;

endmodule // gpeb_lid

// >>> logic/gpeb_pkg.sv
package gpeb_pkg;

    // =================================================================
    // Byte-wide I/O request and answer
    typedef struct packed {
        logic [15:0] addr;
        logic        wr;
        logic        rd;
        logic [7:0]  wdata;
    } gpeb_io_req_s;

    typedef struct packed {
        logic [7:0] rdata;
        logic       rvalid;
    } gpeb_io_rsp_s;

    typedef logic [15:0] gpeb_addr_t;
    typedef logic [7:0]  gpeb_byte_t;

    // =================================================================
    // Decode target of one access
    typedef enum logic [1:0] {
        GPEB_TGT_NONE  = 2'b00,
        GPEB_TGT_FLAGS = 2'b01,
        GPEB_TGT_MASK  = 2'b10,
        GPEB_TGT_LID   = 2'b11
    } gpeb_tgt_e;

endpackage

// >>> logic/gpeb_top.sv
`timescale 1ns/1ps
`include "gpeb_consts.svh"

module gpeb_top #(
    parameter int unsigned NUM_BANKS       = `GPEB_NUM_BANKS,
    parameter int unsigned REG_BYTES       = `GPEB_REG_BYTES,
    parameter logic [15:0] BANK0_BASE      = `GPEB_BANK0_BASE,
    parameter logic [15:0] BANK1_BASE      = `GPEB_BANK1_BASE,
    parameter logic [15:0] LID_ADDR        = `GPEB_LID_ADDR,
    parameter bit          RETAIN_IN_SLEEP = 1'b1,
    parameter bit          WAKE_ENABLE     = 1'b1
) (
    // Clock and reset.
    input  wire logic                        sys_clk,
    input  wire logic                        rstn,
    // Byte-wide system I/O access.
    input  wire gpeb_pkg::gpeb_io_req_s      io_req,
    output gpeb_pkg::gpeb_io_rsp_s           io_rsp,
    // Event inputs, one per flag position.
    input  wire logic [8*REG_BYTES-1:0]      bank0_event,
    input  wire logic [8*REG_BYTES-1:0]      bank1_event,
    // Lid switch level.
    input  wire logic                        lid_in,
    // Power state of the system.
    input  wire logic                        sleeping,
    // Interrupt and wake requests.
    output logic                             sci,
    output logic                             wake
);
    import gpeb_pkg::*;

    // =================================================================
    // Sizes
    // Each register is REG_BYTES wide, so a bank spans twice that.
    localparam int unsigned W     = 8 * REG_BYTES;
    localparam int unsigned NBMAX = `GPEB_MAX_BANKS;

    // Bases are forced onto a dword boundary whatever the parameter.
    localparam logic [NBMAX-1:0][15:0] BASES = {
        BANK1_BASE & `GPEB_ALIGN_MASK,
        BANK0_BASE & `GPEB_ALIGN_MASK
    };

    // =================================================================
    // Shared signals
    logic [NBMAX-1:0][W-1:0] bank_event;
    logic [NBMAX-1:0][7:0]   bank_rd_byte;
    logic [NBMAX-1:0]        bank_hit;
    logic [NBMAX-1:0]        bank_pend;
    logic                    mask_clr_all;
    logic                    lid_hit;
    logic                    lid_wr;
    logic                    lid_flag;
    logic                    lid_polarity;
    logic [7:0]              lid_byte;
    logic [W-1:0]            lid_child;

    // Output and edge registers.
    gpeb_io_rsp_s            rsp_q;
    gpeb_io_rsp_s            rsp_d;
    logic                    sci_q;
    logic                    sci_d;
    logic                    wake_q;
    logic                    wake_d;
    logic                    sleeping_q;
    logic                    sleeping_d;

    // =================================================================
    // Event routing
    // The lid flag is a child source; it is ORed with the pin of the
    // same position, so that pin must stay inactive if unused.
    always_comb begin
        lid_child                      = '0;
        lid_child[`GPEB_LID_CHILD_BIT] = lid_flag;
    end

    assign bank_event[0] = bank0_event | lid_child;
    assign bank_event[1] = bank1_event;

    // =================================================================
    // Lid byte
    assign lid_hit = (io_req.addr == LID_ADDR);
    assign lid_wr  = io_req.wr & lid_hit;

    always_comb begin
        lid_byte                     = `GPEB_RESET_BYTE;
        lid_byte[`GPEB_LID_POLARITY_BIT]  = lid_polarity;
        lid_byte[`GPEB_LID_FLAG_BIT] = lid_flag;
    end

    gpeb_lid u_lid (
        .sys_clk      (sys_clk),
        .rstn         (rstn),
        .lid_in       (lid_in),
        .wr           (lid_wr),
        .wdata        (io_req.wdata),
        .lid_flag     (lid_flag),
        .lid_polarity (lid_polarity)
    );

    // =================================================================
    // Event banks
    for (genvar b = 0; b < NBMAX; b++) begin : g_bank
        if (b < NUM_BANKS) begin : g_on
            gpeb_tgt_e    tgt;
            logic [15:0]  off;
            logic [15:0]  sub;
            logic [W-1:0] wvec;
            logic [W-1:0] lane;
            logic [W-1:0] flag_clr;
            logic [W-1:0] mask_wr;
            logic [W-1:0] flags;
            logic [W-1:0] mask;
            logic [W-1:0] shifted;
            logic [7:0]   rd_byte;
            logic         pend;

            // Byte decode: flags occupy the low half, mask the high.
            always_comb begin
                off = io_req.addr - BASES[b];
                tgt = GPEB_TGT_NONE;
                sub = '0;
                if (off < 16'(REG_BYTES)) begin
                    tgt = GPEB_TGT_FLAGS;
                    sub = off;
                end else if (off < 16'(2 * REG_BYTES)) begin
                    tgt = GPEB_TGT_MASK;
                    sub = off - 16'(REG_BYTES);
                end
            end

            // Every access moves one byte lane only.
            always_comb begin
                wvec     = W'(io_req.wdata) << {sub, 3'b000};
                lane     = W'(8'hFF) << {sub, 3'b000};
                flag_clr = '0;
                mask_wr  = '0;
                if (io_req.wr && tgt == GPEB_TGT_FLAGS) begin
                    flag_clr = wvec;
                end
                if (io_req.wr && tgt == GPEB_TGT_MASK) begin
                    mask_wr = lane;
                end
            end

            // Read lane selection; bits above the width read zero.
            always_comb begin
                shifted = '0;
                unique case (tgt)
                    GPEB_TGT_FLAGS: shifted = flags >> {sub, 3'b000};
                    GPEB_TGT_MASK:  shifted = mask >> {sub, 3'b000};
                    GPEB_TGT_NONE,
                    GPEB_TGT_LID:   shifted = '0;
                endcase
                rd_byte = shifted[7:0];
            end

            gpeb_bank #(
                .WIDTH (W)
            ) u_bank (
                .sys_clk      (sys_clk),
                .rstn         (rstn),
                .event_in     (bank_event[b]),
                .flag_clr     (flag_clr),
                .mask_wr      (mask_wr),
                .mask_wdata   (wvec),
                .mask_clr_all (mask_clr_all),
                .flags        (flags),
                .mask         (mask),
                .pending      (pend)
            );

            assign bank_rd_byte[b] = rd_byte;
            assign bank_hit[b]     = (tgt != GPEB_TGT_NONE);
            assign bank_pend[b]    = pend;
        end else begin : g_off
            assign bank_rd_byte[b] = `GPEB_RESET_BYTE;
            assign bank_hit[b]     = 1'b0;
            assign bank_pend[b]    = 1'b0;
        end
    end

    // =================================================================
    // Sleep handling
    // Without retention the masks are dropped as the system leaves
    // sleep, so firmware finds a known state before handing over.
    always_comb begin
        sleeping_d   = sleeping;
        mask_clr_all = !RETAIN_IN_SLEEP && sleeping_q && !sleeping;
    end

    // =================================================================
    // Read answer and request outputs
    // The lid byte wins over a bank if a base is set to overlap it.
    always_comb begin
        rsp_d        = rsp_q;
        rsp_d.rvalid = io_req.rd;
        if (io_req.rd) begin
            rsp_d.rdata = `GPEB_UNMAPPED_READ;
            for (int b = NBMAX - 1; b >= 0; b--) begin
                if (bank_hit[b]) begin
                    rsp_d.rdata = bank_rd_byte[b];
                end
            end
            if (lid_hit) begin
                rsp_d.rdata = lid_byte;
            end
        end
        sci_d  = |bank_pend;
        wake_d = WAKE_ENABLE && sleeping && (|bank_pend);
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            rsp_q      <= '{rdata: `GPEB_RESET_BYTE, rvalid: 1'b0};
            sci_q      <= 1'b0;
            wake_q     <= 1'b0;
            sleeping_q <= 1'b0;
        end else begin
            rsp_q      <= rsp_d;
            sci_q      <= sci_d;
            wake_q     <= wake_d;
            sleeping_q <= sleeping_d;
        end
    end

    assign io_rsp = rsp_q;
    assign sci    = sci_q;
    assign wake   = wake_q;

endmodule // gpeb_top

// >>> tb/general_purpose_event_blocks_tb_top.sv
`timescale 1ns/1ps

module general_purpose_event_blocks_tb_top;
    import gpeb_pkg::*;

    localparam logic [15:0] B0  = 16'h0400;
    localparam logic [15:0] B1  = 16'h0404;
    localparam logic [15:0] LID = 16'h0200;

    logic         sys_clk = 1'b0;
    logic         rstn = 1'b0;
    gpeb_io_req_s io_req = '0;
    gpeb_io_rsp_s io_rsp;
    logic [7:0]   raw0 = 8'h00, raw1 = 8'h00, ev0, ev1;
    logic         lid_open = 1'b1, lid_level, sleeping = 1'b0, sci, wake;
    int           miscompares = 0, cmp_count = 0;

    always #12.5 sys_clk = ~sys_clk;

    gpeb_plat plat (.raw0(raw0), .raw1(raw1), .lid_open(lid_open),
                    .ev0(ev0), .ev1(ev1), .lid_level(lid_level));
    gpeb_top #(.BANK0_BASE(B0), .BANK1_BASE(B1), .LID_ADDR(LID)) dut (
        .sys_clk(sys_clk), .rstn(rstn), .io_req(io_req), .io_rsp(io_rsp),
        .bank0_event(ev0), .bank1_event(ev1), .lid_in(lid_level),
        .sleeping(sleeping), .sci(sci), .wake(wake));

    // ==========
    // Helpers
    task automatic end_sim;
        $display("compares=%0d mismatches=%0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    task automatic io_wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge sys_clk) io_req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
        @(posedge sys_clk) io_req <= '0;
    endtask

    // Answer lands with the edge that takes the read, so it is sampled just after.
    task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
        @(posedge sys_clk) io_req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
        @(posedge sys_clk) io_req <= '0;
        #1;
        chk({7'h00, io_rsp.rvalid}, 8'h01);
        chk(io_rsp.rdata, exp);
    endtask

    task automatic lvl_chk(input logic es, input logic ew);
        #1;
        chk({6'h00, wake, sci}, {6'h00, ew, es});
    endtask

    // ==========
    // Scenarios
    task automatic t_reset;
        logic [15:0] addrs [5] = '{B0, B0 + 16'h1, B1, B1 + 16'h1, LID};
        @(posedge sys_clk) rstn <= 1'b0;
        tick(2);
        rstn <= 1'b1;
        foreach (addrs[i]) rd_chk(addrs[i], 8'h00);
        lvl_chk(1'b0, 1'b0);
    endtask

    task automatic t_bank(input bit b, input int bitpos);
        logic [15:0] base;
        logic [7:0]  m;
        base = b ? B1 : B0;
        m = 8'h01 << bitpos;
        io_wr(base + 16'h1, m);
        rd_chk(base + 16'h1, m);
        @(posedge sys_clk) if (b) raw1 <= m; else raw0 <= m;
        @(posedge sys_clk) begin raw0 <= 8'h00; raw1 <= 8'h00; end
        tick(2);
        lvl_chk(1'b1, 1'b0);
        rd_chk(base, m);
        io_wr(base, ~m);
        rd_chk(base, m);
        io_wr(base, m);
        tick(2);
        lvl_chk(1'b0, 1'b0);
        rd_chk(base, 8'h00);
        io_wr(base + 16'h1, 8'h00);
    endtask

    task automatic t_pair_sleep;
        @(posedge sys_clk) raw0 <= 8'h08;
        io_wr(B0 + 16'h1, 8'h04);
        tick(3);
        lvl_chk(1'b0, 1'b0);
        io_wr(B0, 8'h08);
        rd_chk(B0, 8'h08);
        io_wr(B0 + 16'h1, 8'h08);
        tick(2);
        lvl_chk(1'b1, 1'b0);
        @(posedge sys_clk) sleeping <= 1'b1;
        tick(2);
        lvl_chk(1'b1, 1'b1);
        rd_chk(B0 + 16'h1, 8'h08);
        @(posedge sys_clk) begin sleeping <= 1'b0; raw0 <= 8'h00; end
        tick(2);
        lvl_chk(1'b1, 1'b0);
        io_wr(B0, 8'h08);
        io_wr(B0 + 16'h1, 8'h00);
    endtask

    task automatic t_lid;
        io_wr(B0 + 16'h1, 8'h02);
        @(posedge sys_clk) lid_open <= 1'b0;
        tick(4);
        rd_chk(LID, 8'h02);
        rd_chk(B0, 8'h02);
        lvl_chk(1'b1, 1'b0);
        // Flip first, then clear: a clear in the flipping write meets a level match and is lost.
        io_wr(LID, 8'h01);
        rd_chk(LID, 8'h03);
        io_wr(LID, 8'h03);
        rd_chk(LID, 8'h01);
        io_wr(B0, 8'h02);
        tick(2);
        lvl_chk(1'b0, 1'b0);
        @(posedge sys_clk) lid_open <= 1'b1;
        tick(4);
        rd_chk(LID, 8'h03);
        lvl_chk(1'b1, 1'b0);
        io_wr(LID, 8'h00);
        io_wr(LID, 8'h02);
        io_wr(B0, 8'h02);
        rd_chk(B0, 8'h00);
        io_wr(B0 + 16'h1, 8'h00);
    endtask

    task automatic t_map;
        rd_chk(16'h0300, 8'h00);
        // Unwired bank 1 pins are strapped low, so pulsing them sets nothing.
        @(posedge sys_clk) raw1 <= 8'h70;
        @(posedge sys_clk) raw1 <= 8'h00;
        rd_chk(B1, 8'h00);
        io_wr(B0 + 16'h2, 8'hFF);
        rd_chk(B0 + 16'h2, 8'h00);
        rd_chk(B0 + 16'h1, 8'h00);
        io_wr(B1 + 16'h1, 8'hFF);
    endtask

    // ==========
    // Run
    initial begin
        repeat (3000) @(posedge sys_clk);
        miscompares++;
        end_sim();
    end

    initial begin
        t_reset();
        t_bank(1'b0, 0);
        t_bank(1'b1, 7);
        t_pair_sleep();
        t_lid();
        t_map();
        t_reset();
        end_sim();
    end
endmodule // general_purpose_event_blocks_tb_top

// >>> tb/gpeb_chk.sv
`timescale 1ns/1ps

module gpeb_chk #(
    parameter int unsigned REG_BYTES = 1,
    parameter logic [15:0] LID_ADDR  = 16'h0200
) (
    // Clock and reset.
    input wire logic                   sys_clk,
    input wire logic                   rstn,
    // Watched ports.
    input wire gpeb_pkg::gpeb_io_req_s io_req,
    input wire gpeb_pkg::gpeb_io_rsp_s io_rsp,
    input wire logic [8*REG_BYTES-1:0] bank0_event,
    input wire logic [8*REG_BYTES-1:0] bank1_event,
    input wire logic                   lid_in,
    input wire logic                   sleeping,
    input wire logic                   sci,
    input wire logic                   wake
);
    import gpeb_pkg::*;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    // ==========
    // Bus answers
    rd_answer_a: assert property (io_req.rd |=> io_rsp.rvalid)
        else $error("read not answered next cycle");
    rvalid_cause_a: assert property (!io_req.rd |=> !io_rsp.rvalid)
        else $error("answer without a read");
    // The first edge after reset still sees pre-reset data, so it is skipped.
    rdata_hold_a: assert property ($past(rstn) && !io_rsp.rvalid |-> $stable(io_rsp.rdata))
        else $error("read data moved without an answer");
    lid_rsvd_a: assert property (io_req.rd && io_req.addr == LID_ADDR
        |=> io_rsp.rdata[7:2] == 6'h00) else $error("lid byte upper bits not zero");
    unmapped_rd_a: assert property (io_req.rd && io_req.addr[15:8] == 8'h03
        |=> io_rsp.rdata == 8'h00) else $error("unmapped read not zero");

    // ==========
    // Interrupt and wake
    wake_sleep_a: assert property (wake |-> $past(sleeping))
        else $error("wake while awake");
    wake_sci_a: assert property (wake |-> sci)
        else $error("wake without pending event");
    sci_fall_a: assert property ($past(rstn) && $fell(sci) |-> $past(io_req.wr, 2))
        else $error("interrupt dropped without a write");

    sci_seen_c: cover property ($rose(sci));
    wake_seen_c: cover property ($rose(wake));
    sci_clr_c: cover property ($past(rstn) && $fell(sci));
endmodule // gpeb_chk

bind gpeb_top gpeb_chk #(.REG_BYTES(REG_BYTES), .LID_ADDR(LID_ADDR)) u_chk (
    .sys_clk(sys_clk), .rstn(rstn), .io_req(io_req), .io_rsp(io_rsp),
    .bank0_event(bank0_event), .bank1_event(bank1_event), .lid_in(lid_in),
    .sleeping(sleeping), .sci(sci), .wake(wake));

// >>> tb/gpeb_plat.sv
`timescale 1ns/1ps

// Platform wiring: pins that carry no event source are strapped inactive.
module gpeb_plat #(
    parameter logic [7:0] WIRED0 = 8'hFF,
    parameter logic [7:0] WIRED1 = 8'h8F
) (
    // Raw sources.
    input wire logic  [7:0] raw0,
    input wire logic  [7:0] raw1,
    input wire logic        lid_open,
    // Pins to the device.
    output logic      [7:0] ev0,
    output logic      [7:0] ev1,
    output logic            lid_level
);
    assign ev0       = raw0 & WIRED0;
    assign ev1       = raw1 & WIRED1;
    assign lid_level = lid_open;
endmodule // gpeb_plat
